/* File: rtl/pin_sense_pkg.sv */
package pin_sense_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int NUM_PORTS = 8;
    localparam int PORT_W = 16;
    localparam int ALL_PINS = NUM_PORTS * PORT_W;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // ************************************************************
    // address map (byte addresses)
    // ************************************************************
    localparam logic [2:0] PORT_C_IDX = 3'h2;
    localparam logic [2:0] PORT_H_IDX = 3'h7;
    localparam int ADDR_GLOBAL_BIT = 10;
    localparam int PORT_SEL_HI = 9;
    localparam int PORT_SEL_LO = 7;
    localparam int PIN_SEL_HI = 5;
    localparam int PIN_SEL_LO = 2;
    localparam int PIN_AREA_BIT = 6;
    localparam logic [4:0] WORD_LATCH = 5'h00;
    localparam logic [4:0] WORD_INPUT = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_FLAG_SUMMARY = 12'h400;
    localparam logic [ADDR_W-1:0] ADDR_GLOBAL_CFG = 12'h404;
    localparam logic [ADDR_W-1:0] ADDR_TDI_CFG = 12'h408;
    localparam logic [ADDR_W-1:0] ADDR_TDO_CFG = 12'h40C;
    localparam logic [ADDR_W-1:0] ADDR_TMS_CFG = 12'h410;
    localparam logic [ADDR_W-1:0] ADDR_TCK_CFG = 12'h414;
    localparam logic [ADDR_W-1:0] ADDR_HSK_CFG = 12'h418;

    // ************************************************************
    // field positions and encodings
    // ************************************************************
    localparam int CFG_SWAP_BIT = 0;
    localparam int CFG_CLK_BIT = 1;
    localparam int DIR_BIT = 6;
    localparam int ODE_BIT = 5;
    localparam int RDS_BIT = 4;
    localparam int PULL_HI = 3;
    localparam int PULL_LO = 2;
    localparam logic [1:0] PULL_DOWN = 2'h2;
    localparam logic [1:0] PULL_UP = 2'h3;

    // ************************************************************
    // writable masks and reset values
    // ************************************************************
    localparam logic [REG_W-1:0] GLOBAL_CFG_MASK = 16'h0003;
    localparam logic [REG_W-1:0] JTAG_IN_MASK = 16'h004C;
    localparam logic [REG_W-1:0] TDO_MASK = 16'h0050;
    localparam logic [REG_W-1:0] HSK_MASK = 16'h007C;
    localparam logic [REG_W-1:0] GLOBAL_CFG_RESET = 16'h0002;
    localparam logic [REG_W-1:0] PIN_CFG_RESET = 16'h0000;
    localparam logic [PORT_W-1:0] LATCH_RESET = 16'h0000;
    localparam logic [PORT_W-1:0] SYNC_RESET = 16'h0000;

endpackage

/* File: rtl/port_pin_sense.sv */
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module port_pin_sense #(
    parameter bit HAS_PORT_H = 1'b1 // port H present on this variant
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // asynchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction, 1 write
    input wire logic [pin_sense_pkg::ADDR_W-1:0] paddr, // apb byte address
    input wire logic [pin_sense_pkg::DATA_W-1:0] pwdata, // apb write data
    output logic [pin_sense_pkg::DATA_W-1:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [pin_sense_pkg::ALL_PINS-1:0] port_pins_in, // pad levels, port x bits 16x+15..16x
    input wire logic [pin_sense_pkg::ALL_PINS-1:0] port_dir, // direction bits, 1 output
    input wire logic [pin_sense_pkg::ALL_PINS-1:0] pin_event_flag, // per-pin interrupt flags
    output logic [pin_sense_pkg::ALL_PINS-1:0] port_output_latch, // stored output latch values
    output logic ext_bus_clock_gate, // 1 enables bus unit clock
    output logic tdi_func_en, // jtag data-in function enabled
    output logic tdi_pin_out, // tdi pad output value
    output logic tdi_pin_oe, // tdi pad output enable
    output logic tdi_pull_up_en, // tdi pull-up on
    output logic tdi_pull_down_en, // tdi pull-down on
    output logic tms_func_en, // jtag mode-select function enabled
    output logic tms_pin_out, // tms pad output value
    output logic tms_pin_oe, // tms pad output enable
    output logic tms_pull_up_en, // tms pull-up on
    output logic tms_pull_down_en, // tms pull-down on
    output logic tck_func_en, // jtag clock function enabled
    output logic tck_pin_out, // tck pad output value
    output logic tck_pin_oe, // tck pad output enable
    output logic tck_pull_up_en, // tck pull-up on
    output logic tck_pull_down_en, // tck pull-down on
    input wire logic tdo_jtag_data, // data from test controller
    input wire logic tdo_jtag_oe, // output enable from test controller
    output logic tdo_func_en, // jtag data-out function enabled
    output logic tdo_pin_out, // tdo pad output value
    output logic tdo_pin_oe, // tdo pad output enable
    output logic tdo_reduced_drive, // tdo drive at one third
    input wire logic hsk_pin_in, // handshake pad level
    input wire logic address_strobe_out, // strobe level from bus unit
    output logic transfer_ack_in, // acknowledge level to bus unit
    output logic hsk_pin_out, // handshake pad output value
    output logic hsk_pin_oe, // handshake pad output enable
    output logic hsk_open_drain, // handshake open-drain drive
    output logic hsk_reduced_drive, // handshake drive at one third
    output logic hsk_pull_up_en, // handshake pull-up on
    output logic hsk_pull_down_en // handshake pull-down on
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [pin_sense_pkg::PORT_W-1:0] latch_reg [pin_sense_pkg::NUM_PORTS];
    logic [pin_sense_pkg::PORT_W-1:0] sync1_reg [pin_sense_pkg::NUM_PORTS];
    logic [pin_sense_pkg::PORT_W-1:0] sync2_reg [pin_sense_pkg::NUM_PORTS];
    logic [pin_sense_pkg::PORT_W-1:0] latch_view [pin_sense_pkg::NUM_PORTS];
    logic [pin_sense_pkg::NUM_PORTS-1:0] summary;
    logic [pin_sense_pkg::REG_W-1:0] global_cfg_reg;
    logic [pin_sense_pkg::REG_W-1:0] tdi_cfg_reg;
    logic [pin_sense_pkg::REG_W-1:0] tdo_cfg_reg;
    logic [pin_sense_pkg::REG_W-1:0] tms_cfg_reg;
    logic [pin_sense_pkg::REG_W-1:0] tck_cfg_reg;
    logic [pin_sense_pkg::REG_W-1:0] hsk_cfg_reg;
    logic [pin_sense_pkg::DATA_W-1:0] prdata_reg;
    logic pslverr_reg;

    // ************************************************************
    // address decode
    // ************************************************************
    logic setup_phase;
    logic write_strobe;
    logic in_port_area;
    logic [2:0] raw_port;
    logic [2:0] port_sel;
    logic [4:0] word_sel;
    logic [3:0] pin_sel;
    logic is_latch;
    logic is_input;
    logic is_pin;
    logic swap_on;

    assign setup_phase = psel && !penable;
    assign write_strobe = psel && penable && pwrite;
    assign in_port_area = !paddr[pin_sense_pkg::ADDR_GLOBAL_BIT] && !paddr[pin_sense_pkg::ADDR_W-1];
    assign raw_port = paddr[pin_sense_pkg::PORT_SEL_HI:pin_sense_pkg::PORT_SEL_LO];
    assign word_sel = paddr[pin_sense_pkg::PIN_AREA_BIT:pin_sense_pkg::PIN_SEL_LO];
    assign pin_sel = paddr[pin_sense_pkg::PIN_SEL_HI:pin_sense_pkg::PIN_SEL_LO];
    assign is_latch = in_port_area && (word_sel == pin_sense_pkg::WORD_LATCH);
    assign is_input = in_port_area && (word_sel == pin_sense_pkg::WORD_INPUT);
    assign is_pin = in_port_area && paddr[pin_sense_pkg::PIN_AREA_BIT];

    // swap of C and H only where H exists
    assign swap_on = global_cfg_reg[pin_sense_pkg::CFG_SWAP_BIT] && HAS_PORT_H;

    // remap the addressed port when swapped
    always_comb begin
        port_sel = raw_port;
        if (swap_on && raw_port == pin_sense_pkg::PORT_C_IDX) begin
            port_sel = pin_sense_pkg::PORT_H_IDX;
        end else if (swap_on && raw_port == pin_sense_pkg::PORT_H_IDX) begin
            port_sel = pin_sense_pkg::PORT_C_IDX;
        end
    end

    // ************************************************************
    // per-port synchroniser, latch view and flag summary
    // ************************************************************
    genvar gp;
    generate
        for (gp = 0; gp < pin_sense_pkg::NUM_PORTS; gp = gp + 1) begin : g_port
            // two flops from pad to input register
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_reg[gp] <= pin_sense_pkg::SYNC_RESET;
                    sync2_reg[gp] <= pin_sense_pkg::SYNC_RESET;
                end else begin
                    sync1_reg[gp] <= port_pins_in[gp*pin_sense_pkg::PORT_W +: pin_sense_pkg::PORT_W];
                    sync2_reg[gp] <= sync1_reg[gp];
                end
            end

            // inputs read the pin, outputs read the stored latch
            assign latch_view[gp] = (port_dir[gp*pin_sense_pkg::PORT_W +: pin_sense_pkg::PORT_W] & latch_reg[gp])
                | (~port_dir[gp*pin_sense_pkg::PORT_W +: pin_sense_pkg::PORT_W] & sync2_reg[gp]);

            // any pending flag in the port
            assign summary[gp] = |pin_event_flag[gp*pin_sense_pkg::PORT_W +: pin_sense_pkg::PORT_W];

            assign port_output_latch[gp*pin_sense_pkg::PORT_W +: pin_sense_pkg::PORT_W] = latch_reg[gp];
        end
    endgenerate

    // ************************************************************
    // output latch, written only by software
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < pin_sense_pkg::NUM_PORTS; i++) begin
                latch_reg[i] <= pin_sense_pkg::LATCH_RESET;
            end
        end else if (write_strobe && is_latch) begin
            latch_reg[port_sel] <= pwdata[pin_sense_pkg::PORT_W-1:0];
        end else if (write_strobe && is_pin) begin
            latch_reg[port_sel][pin_sel] <= pwdata[0];
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_cfg_reg <= pin_sense_pkg::GLOBAL_CFG_RESET;
            tdi_cfg_reg <= pin_sense_pkg::PIN_CFG_RESET;
            tdo_cfg_reg <= pin_sense_pkg::PIN_CFG_RESET;
            tms_cfg_reg <= pin_sense_pkg::PIN_CFG_RESET;
            tck_cfg_reg <= pin_sense_pkg::PIN_CFG_RESET;
            hsk_cfg_reg <= pin_sense_pkg::PIN_CFG_RESET;
        end else if (write_strobe) begin
            case (paddr)
                pin_sense_pkg::ADDR_GLOBAL_CFG: begin
                    global_cfg_reg <= pwdata[pin_sense_pkg::REG_W-1:0] & pin_sense_pkg::GLOBAL_CFG_MASK;
                end
                pin_sense_pkg::ADDR_TDI_CFG: begin
                    tdi_cfg_reg <= pwdata[pin_sense_pkg::REG_W-1:0] & pin_sense_pkg::JTAG_IN_MASK;
                end
                pin_sense_pkg::ADDR_TDO_CFG: begin
                    tdo_cfg_reg <= pwdata[pin_sense_pkg::REG_W-1:0] & pin_sense_pkg::TDO_MASK;
                end
                pin_sense_pkg::ADDR_TMS_CFG: begin
                    tms_cfg_reg <= pwdata[pin_sense_pkg::REG_W-1:0] & pin_sense_pkg::JTAG_IN_MASK;
                end
                pin_sense_pkg::ADDR_TCK_CFG: begin
                    tck_cfg_reg <= pwdata[pin_sense_pkg::REG_W-1:0] & pin_sense_pkg::JTAG_IN_MASK;
                end
                pin_sense_pkg::ADDR_HSK_CFG: begin
                    hsk_cfg_reg <= pwdata[pin_sense_pkg::REG_W-1:0] & pin_sense_pkg::HSK_MASK;
                end
                default: begin
                    // flag summary and input registers ignore writes
                end
            endcase
        end
    end

    // ************************************************************
    // read path, captured in the setup cycle
    // ************************************************************
    logic [pin_sense_pkg::DATA_W-1:0] read_next;
    logic err_next;

    always_comb begin
        read_next = '0;
        err_next = 1'b0;
        if (is_latch) begin
            read_next[pin_sense_pkg::PORT_W-1:0] = latch_view[port_sel];
        end else if (is_input) begin
            read_next[pin_sense_pkg::PORT_W-1:0] = sync2_reg[port_sel];
        end else if (is_pin) begin
            read_next[0] = latch_view[port_sel][pin_sel];
        end else begin
            case (paddr)
                pin_sense_pkg::ADDR_FLAG_SUMMARY: read_next[pin_sense_pkg::NUM_PORTS-1:0] = summary;
                pin_sense_pkg::ADDR_GLOBAL_CFG: read_next[pin_sense_pkg::REG_W-1:0] = global_cfg_reg;
                pin_sense_pkg::ADDR_TDI_CFG: read_next[pin_sense_pkg::REG_W-1:0] = tdi_cfg_reg;
                pin_sense_pkg::ADDR_TDO_CFG: read_next[pin_sense_pkg::REG_W-1:0] = tdo_cfg_reg;
                pin_sense_pkg::ADDR_TMS_CFG: read_next[pin_sense_pkg::REG_W-1:0] = tms_cfg_reg;
                pin_sense_pkg::ADDR_TCK_CFG: read_next[pin_sense_pkg::REG_W-1:0] = tck_cfg_reg;
                pin_sense_pkg::ADDR_HSK_CFG: read_next[pin_sense_pkg::REG_W-1:0] = hsk_cfg_reg;
                default: err_next = 1'b1;
            endcase
        end
    end

    // hold read data and error through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
            pslverr_reg <= 1'b0;
        end else if (setup_phase) begin
            prdata_reg <= pwrite ? '0 : read_next;
            pslverr_reg <= err_next;
        end
    end

    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg && psel && penable;
    assign pready = 1'b1; // data is ready one cycle after setup

    // ************************************************************
    // bus unit clock gate
    // ************************************************************
    assign ext_bus_clock_gate = global_cfg_reg[pin_sense_pkg::CFG_CLK_BIT];

    // ************************************************************
    // jtag input pins: function, drive low, pulls
    // ************************************************************
    assign tdi_func_en = !tdi_cfg_reg[pin_sense_pkg::DIR_BIT];
    assign tdi_pin_oe = tdi_cfg_reg[pin_sense_pkg::DIR_BIT];
    assign tdi_pin_out = 1'b0;
    assign tdi_pull_up_en = tdi_func_en && (tdi_cfg_reg[pin_sense_pkg::PULL_HI:pin_sense_pkg::PULL_LO] == pin_sense_pkg::PULL_UP);
    assign tdi_pull_down_en = tdi_func_en && (tdi_cfg_reg[pin_sense_pkg::PULL_HI:pin_sense_pkg::PULL_LO] == pin_sense_pkg::PULL_DOWN);

    assign tms_func_en = !tms_cfg_reg[pin_sense_pkg::DIR_BIT];
    assign tms_pin_oe = tms_cfg_reg[pin_sense_pkg::DIR_BIT];
    assign tms_pin_out = 1'b0;
    assign tms_pull_up_en = tms_func_en && (tms_cfg_reg[pin_sense_pkg::PULL_HI:pin_sense_pkg::PULL_LO] == pin_sense_pkg::PULL_UP);
    assign tms_pull_down_en = tms_func_en && (tms_cfg_reg[pin_sense_pkg::PULL_HI:pin_sense_pkg::PULL_LO] == pin_sense_pkg::PULL_DOWN);

    assign tck_func_en = !tck_cfg_reg[pin_sense_pkg::DIR_BIT];
    assign tck_pin_oe = tck_cfg_reg[pin_sense_pkg::DIR_BIT];
    assign tck_pin_out = 1'b0;
    assign tck_pull_up_en = tck_func_en && (tck_cfg_reg[pin_sense_pkg::PULL_HI:pin_sense_pkg::PULL_LO] == pin_sense_pkg::PULL_UP);
    assign tck_pull_down_en = tck_func_en && (tck_cfg_reg[pin_sense_pkg::PULL_HI:pin_sense_pkg::PULL_LO] == pin_sense_pkg::PULL_DOWN);

    // ************************************************************
    // jtag data-out pin
    // ************************************************************
    assign tdo_func_en = !tdo_cfg_reg[pin_sense_pkg::DIR_BIT];
    assign tdo_pin_out = tdo_func_en && tdo_jtag_data;
    assign tdo_pin_oe = tdo_func_en ? tdo_jtag_oe : 1'b1;
    assign tdo_reduced_drive = tdo_cfg_reg[pin_sense_pkg::DIR_BIT] && tdo_cfg_reg[pin_sense_pkg::RDS_BIT];

    // ************************************************************
    // shared handshake pin: acknowledge in or strobe out
    // ************************************************************
    logic hsk_strobe_mode;
    assign hsk_strobe_mode = hsk_cfg_reg[pin_sense_pkg::DIR_BIT];
    assign transfer_ack_in = hsk_strobe_mode ? 1'b1 : hsk_pin_in;
    assign hsk_open_drain = hsk_strobe_mode && hsk_cfg_reg[pin_sense_pkg::ODE_BIT];
    assign hsk_pin_out = hsk_open_drain ? 1'b0 : address_strobe_out;
    assign hsk_pin_oe = hsk_strobe_mode && (!hsk_open_drain || !address_strobe_out);
    assign hsk_reduced_drive = hsk_strobe_mode && hsk_cfg_reg[pin_sense_pkg::RDS_BIT];
    assign hsk_pull_up_en = !hsk_strobe_mode && (hsk_cfg_reg[pin_sense_pkg::PULL_HI:pin_sense_pkg::PULL_LO] == pin_sense_pkg::PULL_UP);
    assign hsk_pull_down_en = !hsk_strobe_mode && (hsk_cfg_reg[pin_sense_pkg::PULL_HI:pin_sense_pkg::PULL_LO] == pin_sense_pkg::PULL_DOWN);

endmodule

/* File: verif/port_pin_sense_asserts.sv */
`timescale 1ns/1ps
// ************************************************************
// port checker, sees only the block's ports
// ************************************************************
module port_pin_sense_asserts (
    input wire logic pclk, // system clock
    input wire logic presetn, // reset, active low
    input wire logic psel, penable, pwrite, // apb control
    input wire logic [pin_sense_pkg::ADDR_W-1:0] paddr, // apb address
    input wire logic [pin_sense_pkg::DATA_W-1:0] pwdata, prdata, // apb data
    input wire logic [pin_sense_pkg::ALL_PINS-1:0] pin_event_flag, // per-pin flags
    input wire logic ext_bus_clock_gate, tdi_func_en, tdi_pin_out, tdi_pin_oe, tdi_pull_up_en, tdi_pull_down_en,
    input wire logic tdo_jtag_data, tdo_jtag_oe, tdo_func_en, tdo_pin_out, tdo_pin_oe, tdo_reduced_drive,
    input wire logic hsk_pin_in, address_strobe_out, transfer_ack_in, hsk_pin_out, hsk_pin_oe, // handshake pad
    input wire logic hsk_open_drain, hsk_reduced_drive, hsk_pull_up_en, hsk_pull_down_en // handshake controls
);
    logic [7:0] flag_or;
    // per-port or of the pin flags, the expected summary
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            flag_or[i] = |pin_event_flag[16*i +: 16];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_clk_gate;
        psel && penable && pwrite && paddr == pin_sense_pkg::ADDR_GLOBAL_CFG |=> ext_bus_clock_gate == $past(pwdata[1]);
    endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("clock gate differs from written bit");
    property p_tdi_drive; tdi_pin_oe |-> !tdi_pin_out && !tdi_func_en; endproperty
    a_tdi_drive: assert property (p_tdi_drive) else $error("tdi output not low");
    property p_tdi_pull; tdi_pull_up_en || tdi_pull_down_en |-> !tdi_pin_oe && !(tdi_pull_up_en && tdi_pull_down_en);
    endproperty
    a_tdi_pull: assert property (p_tdi_pull) else $error("tdi pull while output");
    property p_tdo_func; tdo_func_en |-> tdo_pin_out == tdo_jtag_data && tdo_pin_oe == tdo_jtag_oe; endproperty
    a_tdo_func: assert property (p_tdo_func) else $error("tdo path wrong");
    property p_tdo_rds; tdo_reduced_drive |-> !tdo_func_en && tdo_pin_oe; endproperty
    a_tdo_rds: assert property (p_tdo_rds) else $error("tdo reduced drive as input");
    property p_hsk_ack;
        hsk_pull_up_en || hsk_pull_down_en |-> transfer_ack_in == hsk_pin_in && !hsk_pin_oe && !hsk_reduced_drive;
    endproperty
    a_hsk_ack: assert property (p_hsk_ack) else $error("pull outside ack mode");
    property p_hsk_od; hsk_open_drain |-> !hsk_pin_out && hsk_pin_oe == !address_strobe_out && transfer_ack_in;
    endproperty
    a_hsk_od: assert property (p_hsk_od) else $error("open drain strobe wrong");
    property p_summary;
        psel && !penable && !pwrite && paddr == pin_sense_pkg::ADDR_FLAG_SUMMARY |=> prdata == {24'h0, $past(flag_or)};
    endproperty
    a_summary: assert property (p_summary) else $error("flag summary wrong");
    c_summary: cover property (psel && paddr == pin_sense_pkg::ADDR_FLAG_SUMMARY && flag_or != 8'h00);
    c_hsk_od: cover property (hsk_open_drain && !address_strobe_out);
    c_tdo_rds: cover property (tdo_reduced_drive);
endmodule

/* File: verif/pin_board_model.sv */
`timescale 1ns/1ps
// ************************************************************
// board around the port pads
// ************************************************************
module pin_board_model (
    input wire logic [pin_sense_pkg::ALL_PINS-1:0] port_output_latch, // device latch
    input wire logic [pin_sense_pkg::ALL_PINS-1:0] port_dir, // 1 output
    input wire logic [pin_sense_pkg::ALL_PINS-1:0] ext_level, // level from outside
    input wire logic [pin_sense_pkg::ALL_PINS-1:0] short_mask, // outputs shorted to ground
    output logic [pin_sense_pkg::ALL_PINS-1:0] port_pins_in // pad levels
);
    // driven pads follow the latch unless shorted, the rest take the outside level
    assign port_pins_in = (port_dir & port_output_latch & ~short_mask) | (~port_dir & ext_level);
endmodule

/* File: verif/tb_port_pin_sense.sv */
`timescale 1ns/1ps
// ************************************************************
// testbench
// ************************************************************
module tb_port_pin_sense;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, tdo_jtag_data, tdo_jtag_oe;
    logic hsk_pin_in, address_strobe_out, ext_bus_clock_gate, tdo_func_en, tdo_pin_out, tdo_pin_oe, tdo_reduced_drive;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [127:0] port_pins_in, port_dir, pin_event_flag, port_output_latch, ext_level, short_mask;
    logic [4:0] tdi_o, tms_o, tck_o; // func, out, oe, pull up, pull down
    logic [6:0] hsk_o; // ack, out, oe, open drain, reduced, pull up, pull down
    int mismatches, checks_done;
    port_pin_sense #(.HAS_PORT_H(1'h1)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .port_pins_in, .port_dir, .pin_event_flag, .port_output_latch, .ext_bus_clock_gate,
        .tdi_func_en(tdi_o[4]), .tdi_pin_out(tdi_o[3]), .tdi_pin_oe(tdi_o[2]), .tdi_pull_up_en(tdi_o[1]),
        .tdi_pull_down_en(tdi_o[0]), .tms_func_en(tms_o[4]), .tms_pin_out(tms_o[3]), .tms_pin_oe(tms_o[2]),
        .tms_pull_up_en(tms_o[1]), .tms_pull_down_en(tms_o[0]), .tck_func_en(tck_o[4]), .tck_pin_out(tck_o[3]),
        .tck_pin_oe(tck_o[2]), .tck_pull_up_en(tck_o[1]), .tck_pull_down_en(tck_o[0]), .tdo_jtag_data,
        .tdo_jtag_oe, .tdo_func_en, .tdo_pin_out, .tdo_pin_oe, .tdo_reduced_drive, .hsk_pin_in, .address_strobe_out,
        .transfer_ack_in(hsk_o[6]), .hsk_pin_out(hsk_o[5]), .hsk_pin_oe(hsk_o[4]), .hsk_open_drain(hsk_o[3]),
        .hsk_reduced_drive(hsk_o[2]), .hsk_pull_up_en(hsk_o[1]), .hsk_pull_down_en(hsk_o[0]));
    pin_board_model board (.port_output_latch, .port_dir, .ext_level, .short_mask, .port_pins_in);
    // clock, 25 ns period
    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic s_pins;
        @(posedge pclk);
        port_dir[15:0] <= 16'h00FF;
        ext_level[15:0] <= 16'h3C5A;
        short_mask[0] <= 1'h1;
        wr(12'h000, 32'hFFFF_A5A5);
        repeat (3) @(posedge pclk);
        rdchk(12'h004, 32'h0000_3CA4);
        rdchk(12'h000, 32'h0000_3CA5);
        wr(12'h004, 32'h0);
        rdchk(12'h004, 32'h0000_3CA4);
    endtask
    task automatic s_single;
        @(posedge pclk);
        port_dir[15:0] <= 16'h02FF;
        wr(12'h064, 32'h0000_00FF);
        rdchk(12'h064, 32'h0000_0001);
        wr(12'h048, 32'h0);
        rdchk(12'h048, 32'h0);
        rdchk(12'h070, 32'h0000_0001);
        chk({16'h0, port_output_latch[15:0]}, 32'h0000_A7A1);
    endtask
    task automatic s_swap;
        @(posedge pclk);
        port_dir[47:32] <= 16'hFFFF;
        port_dir[127:112] <= 16'hFFFF;
        wr(12'h100, 32'h1111);
        wr(12'h380, 32'h7777);
        wr(12'h404, 32'h0001);
        chk({31'h0, ext_bus_clock_gate}, 32'h0);
        rdchk(12'h100, 32'h7777);
        wr(12'h100, 32'hC0C0);
        chk({16'h0, port_output_latch[127:112]}, 32'hC0C0);
        wr(12'h404, 32'hFFFF);
        rdchk(12'h404, 32'h0003);
        wr(12'h404, 32'h0002);
        rdchk(12'h380, 32'hC0C0);
    endtask
    task automatic s_jtag;
        logic [15:0] v [5];
        logic [4:0] e;
        v = '{16'h000C, 16'h0008, 16'h0004, 16'h004C, 16'h0000};
        foreach (v[i]) begin
            wr(12'h408, {16'h0, v[i] | 16'hFFB3});
            wr(12'h410, {16'h0, v[i] | 16'hFFB3});
            wr(12'h414, {16'h0, v[i] | 16'hFFB3});
            e = {~v[i][6], 1'h0, v[i][6], ~v[i][6] & (v[i][3:2] == 2'h3), ~v[i][6] & (v[i][3:2] == 2'h2)};
            rdchk(12'h410, {16'h0, v[i]});
            chk({17'h0, tdi_o, tms_o, tck_o}, {17'h0, e, e, e});
        end
    endtask
    task automatic s_tdo;
        logic [15:0] v [3];
        v = '{16'h0010, 16'h0050, 16'h0040};
        tdo_jtag_oe <= 1'h1;
        foreach (v[i]) begin
            wr(12'h40C, {16'h0, v[i] | 16'hFFAF});
            rdchk(12'h40C, {16'h0, v[i]});
            chk({28'h0, tdo_func_en, tdo_pin_out, tdo_pin_oe, tdo_reduced_drive},
                {28'h0, v[i][6] ? {3'h1, v[i][4]} : 4'hE});
        end
    endtask
    task automatic s_hsk;
        logic [15:0] v [6];
        logic s, b, od;
        v = '{16'h000C, 16'h0008, 16'h0070, 16'h0050, 16'h0040, 16'h004C};
        foreach (v[i]) begin
            s = i[0];
            @(posedge pclk);
            address_strobe_out <= s;
            hsk_pin_in <= ~s;
            wr(12'h418, {16'h0, v[i] | 16'hFF83});
            b = v[i][6];
            od = b & v[i][5];
            rdchk(12'h418, {16'h0, v[i]});
            chk({25'h0, hsk_o}, {25'h0, b | ~s, ~od & s, b & (~od | ~s), od, b & v[i][4],
                ~b & (v[i][3:2] == 2'h3), ~b & (v[i][3:2] == 2'h2)});
        end
    endtask
    // reset, then one scenario after another
    initial begin
        {psel, penable, pwrite, presetn, address_strobe_out, hsk_pin_in, tdo_jtag_oe} = '0;
        tdo_jtag_data = 1'h1;
        paddr = '0;
        pwdata = '0;
        {port_dir, pin_event_flag, ext_level, short_mask} = '0;
        mismatches = 0;
        checks_done = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        rdchk(12'h404, 32'h0002);
        apb(1'h0, 12'h008, 32'h0);
        chk({31'h0, err}, 32'h1);
        s_pins();
        s_single();
        pin_event_flag[53] <= 1'h1;
        pin_event_flag[111] <= 1'h1;
        rdchk(12'h400, 32'h0048);
        wr(12'h400, 32'hFFFF_FFFF);
        rdchk(12'h400, 32'h0048);
        s_swap();
        s_jtag();
        s_tdo();
        s_hsk();
        test_done();
    end
endmodule
bind port_pin_sense port_pin_sense_asserts chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pin_event_flag, .ext_bus_clock_gate, .tdi_func_en, .tdi_pin_out, .tdi_pin_oe, .tdi_pull_up_en,
    .tdi_pull_down_en, .tdo_jtag_data, .tdo_jtag_oe, .tdo_func_en, .tdo_pin_out, .tdo_pin_oe, .tdo_reduced_drive,
    .hsk_pin_in, .address_strobe_out, .transfer_ack_in, .hsk_pin_out, .hsk_pin_oe, .hsk_open_drain,
    .hsk_reduced_drive, .hsk_pull_up_en, .hsk_pull_down_en);
